// >>> rtl/uda_top.v
// Two-engine address/status/frame block behind a 16-bit word port.
// Processor and parallel host port share it; processor wins a clash.
`timescale 1ns/10ps
module uda_top (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Processor register port
    input wire cpu_sel,
    input wire cpu_wr,
    input wire [15:0] cpu_addr,
    input wire [15:0] cpu_wdata,
    output reg [15:0] cpu_rdata,
    // Parallel host port register access
    input wire parallel_host_port_sel,
    input wire parallel_host_port_wr,
    input wire [15:0] parallel_host_port_addr,
    input wire [15:0] parallel_host_port_wdata,
    output reg [15:0] parallel_host_port_rdata,
    // OTG capable port pins
    input wire otg_capable_port_vbus_valid,
    input wire otg_capable_port_id,
    // Engine one link events
    input wire e1_sof_eop_seen,
    input wire [10:0] e1_sof_frame,
    input wire e1_sof_frame_valid,
    input wire e1_sof_timeout,
    input wire e1_sof_timeout_en,
    input wire e1_bus_reset_seen,
    input wire e1_token_valid,
    input wire [6:0] e1_token_addr,
    input wire [7:0] e1_ep_done,
    input wire [7:0] e1_ep_nak,
    input wire [7:0] e1_ep_nak_irq_en,
    // Engine two link events
    input wire e2_sof_eop_seen,
    input wire [10:0] e2_sof_frame,
    input wire e2_sof_frame_valid,
    input wire e2_sof_timeout,
    input wire e2_sof_timeout_en,
    input wire e2_bus_reset_seen,
    input wire e2_token_valid,
    input wire [6:0] e2_token_addr,
    input wire [7:0] e2_ep_done,
    input wire [7:0] e2_ep_nak,
    input wire [7:0] e2_ep_nak_irq_en,
    // Results
    output reg e1_token_match,
    output reg e2_token_match,
    output reg [15:0] e1_status_out,
    output reg [15:0] e2_status_out
);
`include "uda_map.vh"

////////////////////////////////////////////////////////////////////////
// Decode helper shared by both ports
function hit;
    input sel;
    input [15:0] addr;
    input [15:0] target;
    begin
        hit = sel && (addr == target);
    end
endfunction

wire cpu_wen;
wire hp_wen;
reg wr_go;
reg [15:0] wr_addr;
reg [15:0] wr_data;
wire [15:0] e1_stat;
wire [15:0] e2_stat;
wire [15:0] e1_frame;
wire [15:0] e2_frame;
wire e1_match;
wire e2_match;

assign cpu_wen = cpu_sel && cpu_wr;
assign hp_wen = parallel_host_port_sel && parallel_host_port_wr;

// One write per cycle; processor first, host port write dropped on clash
always @* begin
    wr_go = cpu_wen || hp_wen;
    wr_addr = cpu_wen ? cpu_addr : parallel_host_port_addr;
    wr_data = cpu_wen ? cpu_wdata : parallel_host_port_wdata;
end

////////////////////////////////////////////////////////////////////////
uda_engine #(
    .STAT_MASK(`UDA_ST_MASK1)
) u_eng1 (
    .clk(clk),
    .rst(rst),
    .addr_wr(hit(wr_go, wr_addr, `UDA_E1_ADDR)),
    .stat_wr(hit(wr_go, wr_addr, `UDA_E1_STAT)),
    .wdata(wr_data),
    .otg_vbus_valid(otg_capable_port_vbus_valid),
    .otg_id(otg_capable_port_id),
    .sof_eop_seen(e1_sof_eop_seen),
    .sof_frame(e1_sof_frame),
    .sof_frame_valid(e1_sof_frame_valid),
    .sof_timeout(e1_sof_timeout),
    .sof_timeout_en(e1_sof_timeout_en),
    .bus_reset_seen(e1_bus_reset_seen),
    .token_valid(e1_token_valid),
    .token_addr(e1_token_addr),
    .ep_done(e1_ep_done),
    .ep_nak(e1_ep_nak),
    .ep_nak_irq_en(e1_ep_nak_irq_en),
    .dev_addr(), // Write only; used inside the engine
    .status(e1_stat),
    .frame_reg(e1_frame),
    .token_match(e1_match)
);

// Engine two has no OTG pins; its mask keeps bits 15:14 at zero
uda_engine #(
    .STAT_MASK(`UDA_ST_MASK2)
) u_eng2 (
    .clk(clk),
    .rst(rst),
    .addr_wr(hit(wr_go, wr_addr, `UDA_E2_ADDR)),
    .stat_wr(hit(wr_go, wr_addr, `UDA_E2_STAT)),
    .wdata(wr_data),
    .otg_vbus_valid(1'b0),
    .otg_id(1'b0),
    .sof_eop_seen(e2_sof_eop_seen),
    .sof_frame(e2_sof_frame),
    .sof_frame_valid(e2_sof_frame_valid),
    .sof_timeout(e2_sof_timeout),
    .sof_timeout_en(e2_sof_timeout_en),
    .bus_reset_seen(e2_bus_reset_seen),
    .token_valid(e2_token_valid),
    .token_addr(e2_token_addr),
    .ep_done(e2_ep_done),
    .ep_nak(e2_ep_nak),
    .ep_nak_irq_en(e2_ep_nak_irq_en),
    .dev_addr(),
    .status(e2_stat),
    .frame_reg(e2_frame),
    .token_match(e2_match)
);

////////////////////////////////////////////////////////////////////////
// Address registers are write only and read back as zero
function [15:0] read_mux;
    input sel;
    input [15:0] addr;
    input [15:0] s1;
    input [15:0] f1;
    input [15:0] s2;
    input [15:0] f2;
    begin
        read_mux = 16'h0000;
        if (sel) begin
            case (addr)
                `UDA_E1_STAT: read_mux = s1;
                `UDA_E1_FRAME: read_mux = f1;
                `UDA_E2_STAT: read_mux = s2;
                `UDA_E2_FRAME: read_mux = f2;
                default: read_mux = 16'h0000;
            endcase
        end
    end
endfunction

// Read data registered; reflects state before any same-cycle write
always @(posedge clk) begin
    if (rst) begin
        cpu_rdata <= 16'h0000;
        parallel_host_port_rdata <= 16'h0000;
        e1_token_match <= 1'b0;
        e2_token_match <= 1'b0;
        e1_status_out <= 16'h0000;
        e2_status_out <= 16'h0000;
    end else begin
        cpu_rdata <= read_mux(cpu_sel && !cpu_wr, cpu_addr,
            e1_stat, e1_frame, e2_stat, e2_frame);
        parallel_host_port_rdata <= read_mux(
            parallel_host_port_sel && !parallel_host_port_wr,
            parallel_host_port_addr,
            e1_stat, e1_frame, e2_stat, e2_frame);
        e1_token_match <= e1_match;
        e2_token_match <= e2_match;
        e1_status_out <= e1_stat;
        e2_status_out <= e2_stat;
    end
end

endmodule // uda_top

// >>> rtl/uda_map.vh
// Register offsets, field positions, reset values for the engine pair.
// Assumes 16-bit word registers at printed byte addresses.
`ifndef UDA_MAP_VH
`define UDA_MAP_VH

`define UDA_E1_ADDR 16'hc08e
`define UDA_E1_STAT 16'hc090
`define UDA_E1_FRAME 16'hc092
`define UDA_E2_ADDR 16'hc0ae
`define UDA_E2_STAT 16'hc0b0
`define UDA_E2_FRAME 16'hc0b2

`define UDA_ADDR_RST 7'h00
`define UDA_ADDR_MSB 6
`define UDA_ST_VBUS 15
`define UDA_ST_ID 14
`define UDA_ST_SOF 9
`define UDA_ST_RST 8
`define UDA_ST_EP_MSB 7
`define UDA_FR_FLAG 15
`define UDA_FR_CNT_MSB 14
`define UDA_FR_CNT_LSB 12
`define UDA_FR_NUM_MSB 10
`define UDA_ST_MASK1 16'hc3ff
`define UDA_ST_MASK2 16'h03ff

`endif

// >>> rtl/uda_engine.v
// One engine: address, sticky status flags, frame number register.
// Assumes link events are one-cycle pulses in the clk domain.
`timescale 1ns/10ps
module uda_engine #(
    parameter [15:0] STAT_MASK = 16'hc3ff
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Register access, already decoded
    input wire addr_wr,
    input wire stat_wr,
    input wire [15:0] wdata,
    // Link events
    input wire otg_vbus_valid,
    input wire otg_id,
    input wire sof_eop_seen,
    input wire [10:0] sof_frame,
    input wire sof_frame_valid,
    input wire sof_timeout,
    input wire sof_timeout_en,
    input wire bus_reset_seen,
    input wire token_valid,
    input wire [6:0] token_addr,
    input wire [7:0] ep_done,
    input wire [7:0] ep_nak,
    input wire [7:0] ep_nak_irq_en,
    // State
    output reg [6:0] dev_addr,
    output reg [15:0] status,
    output reg [15:0] frame_reg,
    output reg token_match
);
`include "uda_map.vh"

reg vbus_q;
reg id_q;
reg edges_armed;
reg [15:0] next_status;
reg [15:0] set_bits;

////////////////////////////////////////////////////////////////////////
always @(posedge clk) begin
    if (rst) begin
        dev_addr <= `UDA_ADDR_RST;
    end else if (addr_wr) begin
        dev_addr <= wdata[`UDA_ADDR_MSB:0];
    end
end

always @(posedge clk) begin
    if (rst) begin
        token_match <= 1'b0;
    end else begin
        token_match <= token_valid && (token_addr == dev_addr);
    end
end

////////////////////////////////////////////////////////////////////////
// Edge memory armed after reset so a strapped level makes no flag
always @(posedge clk) begin
    if (rst) begin
        vbus_q <= 1'b0;
        id_q <= 1'b0;
        edges_armed <= 1'b0;
    end else begin
        vbus_q <= otg_vbus_valid;
        id_q <= otg_id;
        edges_armed <= 1'b1;
    end
end

always @* begin
    set_bits = 16'h0000;
    set_bits[`UDA_ST_VBUS] = edges_armed && (vbus_q ^ otg_vbus_valid);
    set_bits[`UDA_ST_ID] = edges_armed && (id_q ^ otg_id);
    set_bits[`UDA_ST_SOF] = sof_eop_seen;
    set_bits[`UDA_ST_RST] = bus_reset_seen;
    set_bits[`UDA_ST_EP_MSB:0] = ep_done
        | (ep_nak & ep_nak_irq_en);
    set_bits = set_bits & STAT_MASK;
    next_status = status;
    if (stat_wr) begin
        next_status = status & ~wdata;
    end
    next_status = (next_status | set_bits) & STAT_MASK;
end

always @(posedge clk) begin
    if (rst) begin
        status <= 16'h0000;
    end else begin
        status <= next_status;
    end
end

////////////////////////////////////////////////////////////////////////
always @(posedge clk) begin
    if (rst) begin
        frame_reg <= 16'h0000;
    end else begin
        if (sof_frame_valid) begin
            frame_reg[`UDA_FR_NUM_MSB:0] <= sof_frame;
        end
        if (sof_eop_seen) begin
            frame_reg[`UDA_FR_CNT_MSB:`UDA_FR_CNT_LSB] <= 3'h0;
        end else if (sof_timeout && sof_timeout_en) begin
            frame_reg[`UDA_FR_CNT_MSB:`UDA_FR_CNT_LSB] <=
                frame_reg[`UDA_FR_CNT_MSB:`UDA_FR_CNT_LSB] + 3'h1;
        end
        if (sof_timeout && sof_timeout_en) begin
            frame_reg[`UDA_FR_FLAG] <= 1'b1;
        end else if (sof_eop_seen) begin
            frame_reg[`UDA_FR_FLAG] <= 1'b0;
        end
    end
end

endmodule // uda_engine

// >>> tb/uda_monitor.sv
// Checker: timing of status flags, token match and register reads.
// Assumes it is bound into uda_top and sees its ports by name.
`timescale 1ns/10ps
module uda_monitor (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Processor port
    input wire cpu_sel,
    input wire cpu_wr,
    input wire [15:0] cpu_addr,
    input wire [15:0] cpu_wdata,
    input wire [15:0] cpu_rdata,
    // Link events and results
    input wire e1_token_valid,
    input wire e1_token_match,
    input wire e2_bus_reset_seen,
    input wire e2_sof_eop_seen,
    input wire [7:0] e1_ep_done,
    input wire [7:0] e1_ep_nak,
    input wire [7:0] e1_ep_nak_irq_en,
    input wire [15:0] e1_status_out,
    input wire [15:0] e2_status_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////
    sequence wr_s;
        cpu_sel && cpu_wr && cpu_addr == 16'hc090;
    endsequence
    // Enabled NAKs set flags too, so they must be quiet as well
    sequence no_set_s;
        e1_ep_done == 8'h00 && (e1_ep_nak & e1_ep_nak_irq_en) == 8'h00;
    endsequence
    ep_done_a: assert property (e1_ep_done != 8'h00 |-> ##2
        (e1_status_out[7:0] & $past(e1_ep_done, 2)) == $past(e1_ep_done, 2))
        else $error("endpoint flag not set");
    rst_flag_a: assert property (
        e2_bus_reset_seen |-> ##2 e2_status_out[8])
        else $error("bus reset flag not set");
    sof_flag_a: assert property (
        e2_sof_eop_seen |-> ##2 e2_status_out[9])
        else $error("frame flag not set");
    rsvd_bits_a: assert property (e2_status_out[15:10] == 6'h00
        && e1_status_out[13:10] == 4'h0) else $error("reserved bit set");
    token_match_a: assert property (
        e1_token_match |-> $past(e1_token_valid, 2))
        else $error("match without token");
    flag_clear_a: assert property (wr_s ##0 no_set_s |-> ##2
        (e1_status_out[7:0] & $past(cpu_wdata[7:0], 2)) == 8'h00)
        else $error("flag not cleared");
    flag_keep_a: assert property (
        wr_s ##0 !cpu_wdata[0] ##1 e1_status_out[0]
        |-> ##1 e1_status_out[0]) else $error("flag lost on zero write");
    set_wins_a: assert property (
        wr_s ##0 cpu_wdata[0] && e1_ep_done[0]
        |-> ##2 e1_status_out[0]) else $error("event lost to clear");
    addr_rd_a: assert property (cpu_sel && !cpu_wr &&
        cpu_addr == 16'hc08e |=> cpu_rdata == 16'h0000)
        else $error("address register readable");
endmodule // uda_monitor

bind uda_top uda_monitor u_mon (.*);

// >>> tb/uda_host_model.sv
// Host side of one engine's link: one-cycle event pulses.
// Assumes events are sampled on the rising edge of clk.
`timescale 1ns/10ps
module uda_host_model (
    // Clock
    input wire clk,
    // Pulses, frame number, token address
    output reg [38:0] ev
);
    initial ev = 39'h0;
    task send(input [20:0] pv, input [10:0] fv, input [6:0] av);
        @(posedge clk);
        #1 ev = {pv, fv, av};
        @(posedge clk);
        // Released fields flip so stale values never look valid
        #1 ev = {21'h0, ~fv, ~av};
    endtask
endmodule // uda_host_model

// >>> tb/usb_device_addr_irq_status_test.sv
// Testbench: accesses on both register ports, events from host models.
// Assumes uda_top with its monitor bound in.
`timescale 1ns/10ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin failures++; \
$display("[ERR] %0t got %h exp %h", $time, a, e); end end
module usb_device_addr_irq_status_test;
    logic clk = 1'b0, rst = 1'b1, cpu_sel = 1'b0, cpu_wr = 1'b0;
    logic parallel_host_port_sel = 1'b0, parallel_host_port_wr = 1'b0;
    logic [15:0] cpu_addr = 16'h0, cpu_wdata = 16'h0;
    logic [15:0] parallel_host_port_addr = 16'h0;
    logic [15:0] parallel_host_port_wdata = 16'h0;
    logic otg_capable_port_vbus_valid = 1'b0, otg_capable_port_id = 1'b0;
    logic e1_sof_timeout_en = 1'b0, e2_sof_timeout_en = 1'b0;
    logic [7:0] e1_ep_nak_irq_en = 8'h0, e2_ep_nak_irq_en = 8'h0;
    wire [15:0] cpu_rdata, parallel_host_port_rdata;
    wire [15:0] e1_status_out, e2_status_out;
    wire e1_token_match, e2_token_match;
    wire [10:0] e1_sof_frame, e2_sof_frame;
    wire [6:0] e1_token_addr, e2_token_addr;
    wire [7:0] e1_ep_done, e2_ep_done, e1_ep_nak, e2_ep_nak;
    wire e1_sof_eop_seen, e1_sof_frame_valid, e1_sof_timeout;
    wire e1_bus_reset_seen, e1_token_valid, e2_sof_eop_seen;
    wire e2_sof_frame_valid, e2_sof_timeout, e2_bus_reset_seen;
    wire e2_token_valid;
    wire [38:0] ev1, ev2;
    int failures = 0, checks_done = 0, cyc = 0;
    assign {e1_sof_eop_seen, e1_sof_frame_valid, e1_sof_timeout,
        e1_bus_reset_seen, e1_token_valid, e1_ep_done, e1_ep_nak,
        e1_sof_frame, e1_token_addr} = ev1;
    assign {e2_sof_eop_seen, e2_sof_frame_valid, e2_sof_timeout,
        e2_bus_reset_seen, e2_token_valid, e2_ep_done, e2_ep_nak,
        e2_sof_frame, e2_token_addr} = ev2;
    uda_top dut (.*);
    uda_host_model h1 (.clk(clk), .ev(ev1));
    uda_host_model h2 (.clk(clk), .ev(ev2));
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            end_sim();
        end
    end
    ////////////////////////////////////////////////////////////////////
    task end_sim();
        if (failures == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task acc(input bit h, input bit w, input [15:0] a, d, x);
        @(posedge clk);
        #1;
        if (h) {parallel_host_port_sel, parallel_host_port_wr,
            parallel_host_port_addr,
            parallel_host_port_wdata} = {1'b1, w, a, d};
        else {cpu_sel, cpu_wr, cpu_addr, cpu_wdata} = {1'b1, w, a, d};
        @(posedge clk);
        #1;
        cpu_sel = 1'b0;
        parallel_host_port_sel = 1'b0;
        if (!w) `CHK(h ? parallel_host_port_rdata : cpu_rdata, x)
    endtask
    task tok(input bit e, input [6:0] ad, input m);
        if (e) h2.send(21'h010000, 11'h0, ad);
        else h1.send(21'h010000, 11'h0, ad);
        @(posedge clk);
        #1 `CHK(e ? e2_token_match : e1_token_match, m)
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk);
        #1 rst = 1'b0;
        acc(0, 0, 16'hc090, 16'h0, 16'h0);
        acc(0, 0, 16'hc092, 16'h0, 16'h0);
        acc(0, 0, 16'hc08e, 16'h0, 16'h0);
        acc(1, 0, 16'hc094, 16'h0, 16'h0);
        tok(0, 7'h00, 1'b1);
        acc(0, 1, 16'hc08e, 16'h0055, 16'h0);
        tok(0, 7'h55, 1'b1);
        tok(0, 7'h00, 1'b0);
        acc(1, 1, 16'hc0ae, 16'h007f, 16'h0);
        tok(1, 7'h7f, 1'b1);
        for (int k = 0; k < 8; k++) begin
            h1.send(21'h100 << k, 11'h0, 7'h0);
            acc(0, 0, 16'hc090, 16'h0, (16'h2 << k) - 16'h1);
        end
        h2.send(21'h1, 11'h0, 7'h0);
        acc(1, 0, 16'hc0b0, 16'h0, 16'h0);
        e2_ep_nak_irq_en = 8'h04;
        h2.send(21'h4, 11'h0, 7'h0);
        h2.send(21'h120000, 11'h0, 7'h0);
        acc(0, 0, 16'hc0b0, 16'h0, 16'h0304);
        @(posedge clk);
        #1 otg_capable_port_vbus_valid = 1'b1;
        @(posedge clk);
        #1 otg_capable_port_id = 1'b1;
        acc(0, 0, 16'hc090, 16'h0, 16'hc0ff);
        acc(1, 0, 16'hc0b0, 16'h0, 16'h0304);
        acc(0, 1, 16'hc090, 16'h8000, 16'h0);
        acc(0, 0, 16'hc090, 16'h0, 16'h40ff);
        @(posedge clk);
        #1 otg_capable_port_vbus_valid = 1'b0;
        acc(0, 0, 16'hc090, 16'h0, 16'hc0ff);
        acc(0, 1, 16'hc090, 16'h00f0, 16'h0);
        acc(0, 0, 16'hc090, 16'h0, 16'hc00f);
        acc(1, 1, 16'hc090, 16'hc00f, 16'h0);
        acc(1, 0, 16'hc090, 16'h0, 16'h0);
        h1.send(21'h100, 11'h0, 7'h0);
        // Clear and new event land on the same edge
        fork
            acc(0, 1, 16'hc090, 16'h0001, 16'h0);
            h1.send(21'h100, 11'h0, 7'h0);
        join
        acc(0, 0, 16'hc090, 16'h0, 16'h0001);
        e1_sof_timeout_en = 1'b1;
        h1.send(21'h080000, 11'h5a5, 7'h0);
        acc(0, 0, 16'hc092, 16'h0, 16'h05a5);
        for (int i = 0; i < 8; i++) begin
            h1.send(21'h040000, 11'h0, 7'h0);
            acc(0, 0, 16'hc092, 16'h0,
                16'h85a5 | (16'((i + 1) & 7) << 12));
        end
        acc(0, 1, 16'hc092, 16'hffff, 16'h0);
        h1.send(21'h100000, 11'h0, 7'h0);
        acc(0, 0, 16'hc092, 16'h0, 16'h05a5);
        // Engine two frame; timeout with its enable low must not count
        h2.send(21'h080000, 11'h123, 7'h0);
        h2.send(21'h040000, 11'h0, 7'h0);
        acc(1, 0, 16'hc0b2, 16'h0, 16'h0123);
        end_sim();
    end
endmodule // usb_device_addr_irq_status_test
